/* fbdp_defines.vh */
// Constants for the front bus data phase controller
// Functional notes
// [R1] The driving agent holds bus-busy asserted while it occupies the data bus. Here pins stay enabled one cycle (ST_REL) after it.
// [R2] Data bus is free only after bus-busy deasserts; nobody drives before that.
// [R3] Addressed agent asserts order_not_guaranteed_n when in-order completion is impossible; input here.
// [R4] Assert a group's inversion flag whenever that group is sent inverted.
// [R5] Invert a group when more than half its bits would change level.
// [R6] Inversion flag bit n covers data group n, sixteen bits each.
// [R7] Driver asserts data-valid on every data transfer.
// [R8] Driver may insert idle clocks by deasserting data-valid; receiver ignores them.
// [R9] Chipset power control reduces power of the data input buffers.
// [R10] Receiver re-inverts a group whose inversion flag is active.
// [R11] Bus is quad-pumped: four data words per common bus clock. The receive path here samples one word per bus clock rise.
// [R12] All control and inversion indications are active low.
`ifndef FBDP_DEFINES_VH
`define FBDP_DEFINES_VH
`define FBDP_DATA_W      64
`define FBDP_GRP_W       16
`define FBDP_GRPS        4
`define FBDP_BEATS       4
`define FBDP_HALF_GRP    5'h08
`define FBDP_BEAT_W      2
`define FBDP_PTR_RST     1'b0
`define FBDP_CNT_RST     2'h0
`endif

/* fbdp_buf2.v */
// Two-entry valid/ready buffer
`timescale 1ns/1ps
`include "fbdp_defines.vh"
module fbdp_buf2 #(
  parameter W = 64
) (
  input  wire         clk_sys,  // System clock
  input  wire         reset,    // Async reset, high
  input  wire [W-1:0] in_data,  // Fill data
  input  wire         in_valid, // Fill valid
  output wire         in_ready, // Not full
  output reg  [W-1:0] out_data, // Head entry, combinational read
  output wire         out_valid,// Not empty
  input  wire         out_ready // Drain accepts
);
  reg [W-1:0] mem_q [0:1];
  reg         wp_q;
  reg         rp_q;
  reg [1:0]   cnt_q;
  wire        wr = in_valid && in_ready;
  wire        rd = out_valid && out_ready;
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  always @*
  begin
    out_data = mem_q[rp_q];
  end
  always @(posedge clk_sys)
  begin
    if (wr)
      mem_q[wp_q] <= in_data;
  end
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wp_q  <= `FBDP_PTR_RST;
      rp_q  <= `FBDP_PTR_RST;
      cnt_q <= `FBDP_CNT_RST;
    end
    else
    begin
      if (wr)
        wp_q <= ~wp_q;
      if (rd)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, wr} - {1'b0, rd};
    end
  end
endmodule

/* fbdp_ctrl.v */
// Front bus data phase: transmit with inversion, receive with re-inversion
`timescale 1ns/1ps
`include "fbdp_defines.vh"
module fbdp_ctrl (
  input  wire        clk_sys,                 // 250 MHz system clock
  input  wire        reset,                   // Async reset, high
  input  wire        bus_clk,                 // Common bus clock, sampled
  input  wire [63:0] tx_data,                 // Word to send
  input  wire        tx_valid,                // Word offered
  output reg         tx_ready_q,              // Word accepted next edge
  output reg  [63:0] rx_data_q,               // Received word, true polarity
  output reg         rx_valid_q,              // Received word pulse
  output reg         order_not_guaranteed_n_seen_q,            // Order_not_guaranteed_n observed, level
  output reg         buf_power_down_q,        // Input buffers powered down
  input  wire [63:0] data_in_n,               // Data pins, input
  output reg  [63:0] data_out_n_q,            // Data pins, output
  output reg         data_oe_n_q,             // Data pin enable, low drives
  input  wire [3:0]  group_inverted_in_n,     // Inversion pins, input
  output reg  [3:0]  group_inverted_out_n_q,  // Inversion pins, output
  output reg         group_inverted_oe_n_q,   // Inversion enable, low drives
  input  wire        data_bus_occupied_in_n,  // Bus-busy pin, input
  output reg         data_bus_occupied_out_n_q, // Bus-busy pin, output
  output reg         data_bus_occupied_oe_n_q,  // Bus-busy enable, low drives
  input  wire        data_valid_in_n,         // Data-valid pin, input
  output reg         data_valid_out_n_q,      // Data-valid pin, output
  output reg         data_valid_oe_n_q,       // Data-valid enable, low drives
  input  wire        order_not_guaranteed_n,  // Order_not_guaranteed_n input
  input  wire        input_buffer_power_ctl_n // Buffer power control
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SEND = 3'b010;
  localparam ST_REL  = 3'b100;

  // Three-stage synchronisers for pins
  reg [2:0] bclk_s_q, busy_s_q, dv_s_q, def_s_q, pwr_s_q;
  reg       bclk_q, busy_q, dv_q;
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      bclk_s_q <= 3'h0;
      busy_s_q <= 3'h7;
      dv_s_q   <= 3'h7;
      def_s_q  <= 3'h7;
      pwr_s_q  <= 3'h7;
      bclk_q   <= 1'b0;
      busy_q   <= 1'b1;
      dv_q     <= 1'b1;
    end
    else
    begin
      bclk_s_q <= {bclk_s_q[1:0], bus_clk};
      busy_s_q <= {busy_s_q[1:0], data_bus_occupied_in_n};
      dv_s_q   <= {dv_s_q[1:0], data_valid_in_n};
      def_s_q  <= {def_s_q[1:0], order_not_guaranteed_n};
      pwr_s_q  <= {pwr_s_q[1:0], input_buffer_power_ctl_n};
      if (bclk_s_q[1] == bclk_s_q[2])
        bclk_q <= bclk_s_q[2];
      if (busy_s_q[1] == busy_s_q[2])
        busy_q <= busy_s_q[2];
      if (dv_s_q[1] == dv_s_q[2])
        dv_q <= dv_s_q[2];
    end
  end

  reg  bclk_d1_q;
  wire bclk_rise = bclk_q && !bclk_d1_q;

  // Buffer between user and pin driver
  wire [63:0] bf_data;
  wire        bf_valid;
  wire        bf_in_ready;
  reg         bf_take;
  fbdp_buf2 #(.W(`FBDP_DATA_W)) fbdp_buf2_inst (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_data   (tx_data),
    .in_valid  (tx_valid && tx_ready_q),
    .in_ready  (bf_in_ready),
    .out_data  (bf_data),
    .out_valid (bf_valid),
    .out_ready (bf_take)
  );

  // Per-group inversion decision against the last driven pin level
  wire [63:0] enc_data;
  wire [3:0]  enc_inv_n;
  genvar g;
  generate
    for (g = 0; g < `FBDP_GRPS; g = g + 1)
    begin : g_inv
      wire [15:0] flips = ~bf_data[g*16 +: 16] ^ data_out_n_q[g*16 +: 16];
      reg  [4:0]  ones;
      integer     i;
      always @*
      begin
        ones = 5'h00;
        for (i = 0; i < `FBDP_GRP_W; i = i + 1)
          ones = ones + {4'h0, flips[i]};
      end
      wire        do_inv = (ones > `FBDP_HALF_GRP);        // [R5] [R6]
      // Inverted group goes out as true bits on the active-low wire
      assign enc_data[g*16 +: 16] = do_inv ? bf_data[g*16 +: 16] : ~bf_data[g*16 +: 16];
      assign enc_inv_n[g]         = ~do_inv;               // [R4] [R12]
    end
  endgenerate

  reg [2:0] st_q;
  reg [1:0] beat_q;
  reg       word_sent;
  always @*
  begin
    bf_take   = 1'b0;
    word_sent = 1'b0;
    if (st_q == ST_SEND && bf_valid && !(beat_q == 2'h0 && !bclk_rise))
    begin
      bf_take   = 1'b1;
      word_sent = 1'b1;
    end
  end

  // Transmit state machine
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st_q                      <= ST_IDLE;
      beat_q                    <= `FBDP_CNT_RST;
      bclk_d1_q                 <= 1'b0;
      tx_ready_q                <= 1'b0;
      data_out_n_q              <= {64{1'b1}};
      data_oe_n_q               <= 1'b1;
      group_inverted_out_n_q    <= 4'hf;
      group_inverted_oe_n_q     <= 1'b1;
      data_bus_occupied_out_n_q <= 1'b1;
      data_bus_occupied_oe_n_q  <= 1'b1;
      data_valid_out_n_q        <= 1'b1;
      data_valid_oe_n_q         <= 1'b1;
    end
    else
    begin
      bclk_d1_q  <= bclk_q;
      tx_ready_q <= bf_in_ready && !(tx_valid && tx_ready_q && bf_in_ready && !bf_take);
      case (st_q)
        ST_IDLE:
        begin
          if (bf_valid && bclk_rise && busy_q)               // [R2]
          begin
            st_q                      <= ST_SEND;
            data_bus_occupied_out_n_q <= 1'b0;               // [R1] [R12]
            data_bus_occupied_oe_n_q  <= 1'b0;
            data_valid_oe_n_q         <= 1'b0;
            data_oe_n_q               <= 1'b0;
            group_inverted_oe_n_q     <= 1'b0;
          end
        end
        ST_SEND:
        begin
          if (word_sent)
          begin
            data_out_n_q           <= enc_data;
            group_inverted_out_n_q <= enc_inv_n;             // [R4]
            data_valid_out_n_q     <= 1'b0;                  // [R7]
            // A bus clock edge always opens a fresh group of four
            beat_q                 <= bclk_rise ? 2'h1 : beat_q + 2'h1; // [R11]
          end
          else
          begin
            // No word this cycle: idle clock, never a repeated word
            data_valid_out_n_q <= 1'b1;                      // [R8]
            if (bclk_rise)
            begin
              beat_q                    <= `FBDP_CNT_RST;
              st_q                      <= ST_REL;
              data_bus_occupied_out_n_q <= 1'b1;             // [R1]
            end
          end
        end
        ST_REL:
        begin
          st_q                      <= ST_IDLE;
          data_bus_occupied_oe_n_q  <= 1'b1;
          data_valid_oe_n_q         <= 1'b1;
          data_oe_n_q               <= 1'b1;
          group_inverted_oe_n_q     <= 1'b1;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // Receive path; data sampled when the other agent marks it valid
  reg [63:0] rx_true;
  integer k;
  always @*
  begin
    rx_true = ~data_in_n;
    for (k = 0; k < `FBDP_GRPS; k = k + 1)
      if (!group_inverted_in_n[k])
        rx_true[k*16 +: 16] = data_in_n[k*16 +: 16];     // [R10] [R6]
  end

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rx_data_q        <= {64{1'b0}};
      rx_valid_q       <= 1'b0;
      order_not_guaranteed_n_seen_q     <= 1'b0;
      buf_power_down_q <= 1'b0;
    end
    else
    begin
      if (def_s_q[1] == def_s_q[2])
        order_not_guaranteed_n_seen_q <= !def_s_q[2];                       // [R3]
      if (pwr_s_q[1] == pwr_s_q[2])
        buf_power_down_q <= !pwr_s_q[2];                   // [R9]
      rx_valid_q       <= 1'b0;
      if (bclk_rise && !dv_q && !busy_q && st_q == ST_IDLE && !buf_power_down_q)
      begin
        rx_data_q  <= rx_true;                             // [R8] [R11]
        rx_valid_q <= 1'b1;
      end
    end
  end
endmodule

/* fbdp_ctrl_assertions.sv */
// Concurrent checks on the data phase controller ports
`timescale 1ns/1ps
module fbdp_chk (
  input wire        clk_sys,                   // Clock
  input wire        reset,                     // Reset
  input wire [63:0] data_out_n_q,              // Data pins
  input wire        data_oe_n_q,               // Data enable
  input wire        group_inverted_oe_n_q,     // Flag enable
  input wire        data_bus_occupied_in_n,    // Busy wire
  input wire        data_bus_occupied_out_n_q, // Busy out
  input wire        data_bus_occupied_oe_n_q,  // Busy enable
  input wire        data_valid_out_n_q,        // Valid out
  input wire        data_valid_oe_n_q,         // Valid enable
  input wire        rx_valid_q,                // Rx pulse
  input wire        buf_power_down_q,          // Power down
  input wire        input_buffer_power_ctl_n,  // Power control
  input wire        order_not_guaranteed_n,    // Order_not_guaranteed_n input
  input wire        order_not_guaranteed_n_seen_q               // Order_not_guaranteed_n level
);
  reg  [63:0] prev_q;
  wire [63:0] tg = data_out_n_q ^ prev_q;
  wire        tog_ok = ($countones(tg[15:0]) <= 8) && ($countones(tg[31:16]) <= 8) &&
                       ($countones(tg[47:32]) <= 8) && ($countones(tg[63:48]) <= 8);
  always @(posedge clk_sys or posedge reset)
    if (reset)
      prev_q <= 64'hffff_ffff_ffff_ffff;
    else
      prev_q <= data_out_n_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_beat;
    !data_valid_oe_n_q && !data_valid_out_n_q;
  endsequence
  sequence s_first_beat;
    s_beat ##0 $fell(data_valid_out_n_q);
  endsequence
  a_busy_on_beat: assert property (s_beat |-> !data_bus_occupied_out_n_q && !data_bus_occupied_oe_n_q)
    else $error("beat without busy");
  a_busy_leads: assert property (s_first_beat |-> $past(data_bus_occupied_out_n_q) == 1'b0)
    else $error("busy not ahead of data");
  a_release_after: assert property ($rose(data_bus_occupied_out_n_q) |=> data_oe_n_q && data_valid_oe_n_q)
    else $error("pins held after busy");
  a_no_clash: assert property (!$past(data_bus_occupied_in_n, 4) && !data_bus_occupied_in_n
    && data_bus_occupied_oe_n_q |-> data_oe_n_q)
    else $error("drive while other busy");
  a_toggle_limit: assert property (s_beat |-> tog_ok)
    else $error("group toggles above half");
  a_flags_driven: assert property (s_beat |-> !group_inverted_oe_n_q && !data_oe_n_q)
    else $error("flags not driven");
  a_rx_single: assert property (rx_valid_q |=> !rx_valid_q [*8])
    else $error("rx pulse too long");
  a_power_block: assert property (buf_power_down_q [*2] |=> !rx_valid_q)
    else $error("rx while powered down");
  a_power_follow: assert property ($fell(input_buffer_power_ctl_n) |-> ##[1:5] buf_power_down_q)
    else $error("power down late");
  a_order_not_guaranteed_n_follow: assert property ($fell(order_not_guaranteed_n) |-> ##[1:5] order_not_guaranteed_n_seen_q)
    else $error("order_not_guaranteed_n not seen");
endmodule

bind fbdp_ctrl fbdp_chk fbdp_chk_inst (.*);

/* fbdp_agent.sv */
// Chipset-side bus agent model
`timescale 1ns/1ps
module fbdp_agent (
  input  wire        bus_clk,          // Common bus clock
  input  wire        hold,             // Occupy the data bus
  input  wire        go,               // Send word this clock
  input  wire [63:0] word,             // Word to send
  input  wire [63:0] d_w,              // Data wire level
  output reg         bsy_n_q = 1'b1,   // Busy pin
  output reg         vld_n_q = 1'b1,   // Valid pin
  output reg  [3:0]  inv_n_q = 4'hf,   // Inversion pins
  output reg  [63:0] dat_q = {64{1'b1}} // Data pins
);
  reg [15:0] p;
  integer    g;
  always @(posedge bus_clk)
  begin
    bsy_n_q <= ~hold;
    vld_n_q <= ~(go & hold);
    if (go & hold)
    begin
      for (g = 0; g < 4; g = g + 1)
      begin
        p = ~word[16*g+:16];
        inv_n_q[g] <= ($countones(p ^ d_w[16*g+:16]) > 8) ? 1'b0 : 1'b1;
        dat_q[16*g+:16] <= ($countones(p ^ d_w[16*g+:16]) > 8) ? ~p : p;
      end
    end
  end
endmodule

/* front_bus_data_phase_control_test.sv */
// Self-checking bench for the data phase controller
`timescale 1ns/1ps
module front_bus_data_phase_control_test;
  reg         clk_sys, reset, bus_clk, tx_valid, hold, go;
  reg         order_not_guaranteed_n, input_buffer_power_ctl_n;
  reg  [63:0] tx_data, word;
  reg  [63:0] txq[$], rxq[$], wl[0:4];
  integer     error_cnt, checks;
  wire [63:0] data_in_n, data_out_n_q, rx_data_q, agt_dat;
  wire [3:0]  group_inverted_in_n, group_inverted_out_n_q, agt_inv_n;
  wire        tx_ready_q, rx_valid_q, order_not_guaranteed_n_seen_q, buf_power_down_q, data_oe_n_q, group_inverted_oe_n_q;
  wire        data_bus_occupied_in_n, data_bus_occupied_out_n_q, data_bus_occupied_oe_n_q, agt_bsy_n;
  wire        data_valid_in_n, data_valid_out_n_q, data_valid_oe_n_q, agt_vld_n;
  // Terminated bus: released lines read high
  assign data_bus_occupied_in_n = agt_bsy_n & (data_bus_occupied_oe_n_q | data_bus_occupied_out_n_q);
  assign data_valid_in_n = agt_vld_n & (data_valid_oe_n_q | data_valid_out_n_q);
  assign group_inverted_in_n = agt_bsy_n ? (group_inverted_oe_n_q ? 4'hf : group_inverted_out_n_q) : agt_inv_n;
  assign data_in_n = agt_bsy_n ? (data_oe_n_q ? 64'hffff_ffff_ffff_ffff : data_out_n_q) : agt_dat;
  fbdp_ctrl fbdp_ctrl_inst (.*);
  fbdp_agent fbdp_agent_inst (.bus_clk(bus_clk), .hold(hold), .go(go), .word(word), .d_w(data_in_n),
    .bsy_n_q(agt_bsy_n), .vld_n_q(agt_vld_n), .inv_n_q(agt_inv_n), .dat_q(agt_dat));
  function [63:0] dec(input [63:0] p, input [3:0] f);
    integer g;
    begin
      for (g = 0; g < 4; g = g + 1)
        dec[16*g+:16] = f[g] ? ~p[16*g+:16] : p[16*g+:16];
    end
  endfunction
  always @(posedge clk_sys)
  begin
    if (!data_valid_oe_n_q && !data_valid_out_n_q)
      txq.push_back(dec(data_out_n_q, group_inverted_out_n_q));
    if (rx_valid_q)
      rxq.push_back(rx_data_q);
  end
  task chk(input [63:0] e, input [63:0] g);
    begin
      checks = checks + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  task bclk(input integer n);
    begin
      repeat (n) @(posedge bus_clk);
      @(posedge clk_sys);
    end
  endtask
  task wq(input integer n);
    integer k;
    begin
      for (k = 0; k < 1000 && txq.size() < n; k = k + 1)
        @(posedge clk_sys);
    end
  endtask
  task wrel;
    integer k;
    begin
      for (k = 0; k < 200 && !data_bus_occupied_oe_n_q; k = k + 1)
        @(posedge clk_sys);
      @(posedge clk_sys);
      chk(64'h7, {data_bus_occupied_out_n_q, data_bus_occupied_oe_n_q, data_oe_n_q});
    end
  endtask
  task t_tx;
    integer i;
    reg     refused;
    begin
      refused = 1'b0;
      i = 0;
      tx_valid <= 1'b1;
      tx_data <= wl[0];
      while (i < 5)
      begin
        @(posedge clk_sys);
        if (tx_ready_q)
        begin
          i = i + 1;
          tx_data <= wl[i % 5];
        end
        else
          refused = 1'b1;
      end
      tx_valid <= 1'b0;
      wq(5);
      chk(64'h1, refused);
      for (i = 0; i < 5; i = i + 1)
        chk(wl[i], txq[i]);
      wrel;
      txq.delete();
    end
  endtask
  task t_rx;
    begin
      hold <= 1'b1;
      bclk(1);
      word <= wl[3];
      go <= 1'b1;
      tx_data <= wl[2];
      tx_valid <= 1'b1;
      @(posedge clk_sys);
      tx_valid <= 1'b0;
      bclk(1);
      go <= 1'b0;
      bclk(1);
      word <= wl[4];
      go <= 1'b1;
      bclk(1);
      go <= 1'b0;
      hold <= 1'b0;
      bclk(1);
      chk(64'h2, rxq.size());
      chk(wl[3], rxq[0]);
      chk(wl[4], rxq[1]);
      wq(1);
      chk(wl[2], txq[0]);
      wrel;
      rxq.delete();
      txq.delete();
    end
  endtask
  task t_pwr;
    begin
      input_buffer_power_ctl_n <= 1'b0;
      order_not_guaranteed_n <= 1'b0;
      bclk(1);
      hold <= 1'b1;
      go <= 1'b1;
      word <= wl[1];
      bclk(1);
      hold <= 1'b0;
      go <= 1'b0;
      bclk(2);
      chk(64'h3, {buf_power_down_q, order_not_guaranteed_n_seen_q});
      chk(64'h0, rxq.size());
      input_buffer_power_ctl_n <= 1'b1;
      order_not_guaranteed_n <= 1'b1;
      bclk(1);
      chk(64'h0, {buf_power_down_q, order_not_guaranteed_n_seen_q});
    end
  endtask
  task tally_and_finish;
    begin
      if (error_cnt == 0 && checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial
  begin
    bus_clk = 1'b0;
    #3.3;
    forever #62.5 bus_clk = ~bus_clk;
  end
  initial
  begin
    #60000;
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
  initial
  begin
    error_cnt = 0;
    checks = 0;
    reset = 1'b1;
    {tx_valid, hold, go} = 3'h0;
    {order_not_guaranteed_n, input_buffer_power_ctl_n} = 2'h3;
    tx_data = 64'h0;
    word = 64'h0;
    wl[0] = 64'h0;
    wl[1] = 64'hffff_ffff_ffff_ffff;
    wl[2] = 64'h00ff_ff00_0f0f_1234;
    wl[3] = 64'hffff_0000_fe01_0000;
    wl[4] = 64'h5555_aaaa_ffff_0001;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_tx;
    t_rx;
    t_pwr;
    tally_and_finish;
  end
endmodule
